// >>> core/osc_octal_uart.sv
`timescale 1ns/1ns
// Function
// - Eight independent full-duplex serial lines
// - Sixteen rates, chosen per receiver and transmitter
// - Mode two holds rx and tx rates
// - Mode one: stops, parity, length, modem enable
// - Per-line command register for other controls
// - Assembly stage plus two-entry receive queue
// - Transmit holding register buffers outgoing character
// - Read-only status register per line
// - Scanner favours receivers over transmitters
// - Interrupt summary gives line and direction
// - Modem changes interrupt only when fully enabled
// - Per-line data-set-change flag until cleared
// - Interrupt request plus three line-number outputs
// - Direction output marks transmit or receive
// - Six select bits choose the register
// - Bus active only while chip select low
// - Write input sets data direction
// - Ready shows device can complete transfer
// - Reset initialises all internal logic
// - Interrupt enables independent for each line
// - Read values held stable during access
module osc_octal_uart
   import osc_pkg::*;
#(
   parameter int CLK_HZ_P = CLK_HZ // Lower it to shorten bit times
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // Host parallel port
   input  wire logic [5:0] register_select_bits,
   input  wire logic       chip_select_n,
   input  wire logic [1:0] data_strobe_pair_n,
   input  wire logic       write_n,
   input  wire logic [7:0] parallel_data_lines_in,
   output wire logic [7:0] parallel_data_lines_out,
   output wire logic       parallel_data_lines_oe,
   output wire logic       ready,
   // Interrupt report
   output wire logic       irq,
   output wire logic [2:0] interrupt_source_line_number,
   output wire logic       interrupt_direction_flag,
   // Serial lines and modem status
   input  wire logic [7:0] serial_input_lines,
   output wire logic [7:0] serial_output_lines,
   input  wire logic [7:0] dsr_in,
   input  wire logic [7:0] dcd_in
);

   // Clock cycles per bit for a rate code
   function automatic logic [19:0] bit_div(input logic [3:0] sel);
      bit_div = 20'(CLK_HZ_P * 10 / osc_rate_x10(sel));
   endfunction : bit_div

   logic [SYNC_W-1:0] s1_q, s2_q, s3_q; // Three-stage pin synchroniser
   osc_pins_s         f_q;              // Filtered pin image
   wire  [SYNC_W-1:0] pins_w = {serial_input_lines, dsr_in, dcd_in,
                                chip_select_n, write_n, data_strobe_pair_n,
                                register_select_bits, parallel_data_lines_in};
   wire  [SYNC_W-1:0] agree_w = ~(s2_q ^ s3_q);

   // Pin sync; a change counts once stages two and three agree
   always_ff @(posedge clk or posedge reset) begin : p_sync
      if (reset) begin
         s1_q <= SYNC_RST;
         s2_q <= SYNC_RST;
         s3_q <= SYNC_RST;
         f_q  <= osc_pins_s'(SYNC_RST);
      end else begin
         s1_q <= pins_w;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q  <= osc_pins_s'((s2_q & agree_w) | (f_q & ~agree_w));
      end
   end

   // Host access decode
   wire       acc = !f_q.cs_n && f_q.ds_n == 2'b00;
   logic      acc_q;                                // Access seen last cycle
   wire       start = acc && !acc_q;
   wire       wr_go = start && !f_q.wr_n;
   wire       rd_go = start && f_q.wr_n;
   wire [2:0] sel_line = f_q.sel[5:3];
   wire [2:0] sel_kind = f_q.sel[2:0];

   osc_mode1_s  m1_q [LINES];  // Framing per line
   osc_mode2_s  m2_q [LINES];  // Rates per line
   osc_cmd_s    cmd_q [LINES]; // Commands per line
   logic [7:0]  rdat_w [LINES]; // Per-line read value
   wire  [7:0]  rx_pend, tx_pend, chg_w;
   logic [7:0]  dsc_q;         // Data-set-change flags
   osc_isum_s   isum_q;        // Registered scanner result
   logic [7:0]  dout_q;        // Latched read data
   logic        oe_q, rdy_q;
   logic [7:0]  rd_val;
   logic        sc_hit, sc_dir;
   logic [2:0]  sc_line;

   for (genvar i = 0; i < LINES; i++) begin : g_line
      wire        hit = sel_line == 3'(i);
      // Filtered data only; the raw pin may still be settling
      wire        clr_err = wr_go && hit && sel_kind == REG_CMD &&
                            f_q.din[7];
      wire [19:0] rdiv = bit_div(m2_q[i].rx_rate);
      wire [19:0] tdiv = bit_div(m2_q[i].tx_rate);
      wire [2:0]  last = 3'h4 + {1'b0, m1_q[i].len};
      wire [7:0]  mask = 8'hff >> (3'h7 - last);
      wire        rx = f_q.rxd[i];
      osc_ser_e   rst_q, tst_q;        // Receive and transmit states
      logic [19:0] rcnt_q, tcnt_q;     // Bit timers
      logic [2:0] rbit_q, tbit_q;      // Bit indices
      logic [7:0] rsh_q, tsh_q;        // Assembly and shift registers
      logic       push_q, pe_q, fe_q;  // Character done and its errors
      logic [7:0] f0_q, f1_q;          // Receive queue entries
      logic [1:0] fcnt_q;              // Queue fill level
      logic       ovr_q, perr_q, ferr_q;
      logic [7:0] hold_q;              // Transmit holding register
      logic       hfull_q, txd_q;
      logic [1:0] mprev_q;             // Last seen dsr, dcd
      wire        pop = rd_go && hit && sel_kind == REG_DATA &&
                        fcnt_q != 2'h0;
      osc_status_s st;

      // Configuration writes
      always_ff @(posedge clk or posedge reset) begin : p_cfg
         if (reset) begin
            m1_q[i]  <= osc_mode1_s'(MODE1_RST);
            m2_q[i]  <= osc_mode2_s'(MODE2_RST);
            cmd_q[i] <= osc_cmd_s'(CMD_RST);
         end else if (wr_go && hit) begin
            case (sel_kind)
               REG_MODE1: m1_q[i] <= osc_mode1_s'(f_q.din);
               REG_MODE2: m2_q[i] <= osc_mode2_s'(f_q.din);
               REG_CMD:   cmd_q[i] <= osc_cmd_s'({1'b0, f_q.din[6:0]});
               default: ;
            endcase
         end
      end

      // Receiver; start bit checked again at its middle
      always_ff @(posedge clk or posedge reset) begin : p_rx
         if (reset) begin
            rst_q  <= S_IDLE;
            rcnt_q <= 20'h0;
            rbit_q <= 3'h0;
            rsh_q  <= 8'h00;
            push_q <= 1'b0;
            pe_q   <= 1'b0;
            fe_q   <= 1'b0;
         end else begin
            push_q <= 1'b0;
            if (rcnt_q != 20'h0) begin
               rcnt_q <= rcnt_q - 20'h1;
            end else begin
               case (rst_q)
                  S_IDLE: if (!rx && cmd_q[i].rx_en) begin
                     rst_q  <= S_START;
                     rcnt_q <= {1'b0, rdiv[19:1]};
                  end
                  S_START: begin
                     rst_q  <= rx ? S_IDLE : S_DATA; // Glitch rejected
                     rcnt_q <= rdiv - 20'h1;
                     rbit_q <= 3'h0;
                     rsh_q  <= 8'h00;
                     pe_q   <= 1'b0;
                  end
                  S_DATA: begin
                     rsh_q[rbit_q] <= rx;
                     rbit_q <= rbit_q + 3'h1;
                     rcnt_q <= rdiv - 20'h1;
                     if (rbit_q == last) begin
                        rst_q <= m1_q[i].par_en ? S_PAR : S_STOP;
                     end
                  end
                  S_PAR: begin
                     pe_q   <= rx != (^(rsh_q & mask) ^ m1_q[i].par_odd);
                     rcnt_q <= rdiv - 20'h1;
                     rst_q  <= S_STOP;
                  end
                  S_STOP: begin // Only the first stop bit is checked
                     fe_q   <= !rx;
                     push_q <= 1'b1;
                     rst_q  <= S_IDLE;
                  end
                  default: rst_q <= S_IDLE;
               endcase
            end
         end
      end

      // Receive queue behind the assembly stage
      always_ff @(posedge clk or posedge reset) begin : p_fifo
         if (reset) begin
            f0_q   <= 8'h00;
            f1_q   <= 8'h00;
            fcnt_q <= 2'h0;
         end else begin
            case ({push_q, pop})
               2'b10: if (fcnt_q != 2'h2) begin // Full queue drops it
                  if (fcnt_q == 2'h0) f0_q <= rsh_q;
                  else f1_q <= rsh_q;
                  fcnt_q <= fcnt_q + 2'h1;
               end
               2'b01: begin
                  f0_q   <= f1_q;
                  fcnt_q <= fcnt_q - 2'h1;
               end
               2'b11: begin
                  f0_q <= (fcnt_q == 2'h1) ? rsh_q : f1_q;
                  f1_q <= rsh_q;
               end
               default: ;
            endcase
         end
      end

      // Sticky errors; a new error beats a clear in the same cycle
      always_ff @(posedge clk or posedge reset) begin : p_err
         if (reset) begin
            ovr_q  <= 1'b0;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
         end else begin
            ovr_q  <= (push_q && !pop && fcnt_q == 2'h2) ||
                      (ovr_q && !clr_err);
            perr_q <= (push_q && pe_q) || (perr_q && !clr_err);
            ferr_q <= (push_q && fe_q) || (ferr_q && !clr_err);
         end
      end

      // Transmitter; writes to a full holding register are ignored
      always_ff @(posedge clk or posedge reset) begin : p_tx
         if (reset) begin
            tst_q   <= S_IDLE;
            tcnt_q  <= 20'h0;
            tbit_q  <= 3'h0;
            tsh_q   <= 8'h00;
            hold_q  <= 8'h00;
            hfull_q <= 1'b0;
            txd_q   <= 1'b1;
         end else begin
            if (wr_go && hit && sel_kind == REG_DATA && !hfull_q) begin
               hold_q  <= f_q.din;
               hfull_q <= 1'b1;
            end
            if (tcnt_q != 20'h0) begin
               tcnt_q <= tcnt_q - 20'h1;
            end else begin
               case (tst_q)
                  S_IDLE: if (hfull_q && cmd_q[i].tx_en) begin
                     tsh_q   <= hold_q & mask;
                     hfull_q <= 1'b0;
                     txd_q   <= 1'b0;
                     tbit_q  <= 3'h0;
                     tcnt_q  <= tdiv - 20'h1;
                     tst_q   <= S_DATA;
                  end
                  S_DATA: begin
                     txd_q  <= tsh_q[tbit_q];
                     tbit_q <= tbit_q + 3'h1;
                     tcnt_q <= tdiv - 20'h1;
                     if (tbit_q == last) begin
                        tst_q <= m1_q[i].par_en ? S_PAR : S_STOP;
                     end
                  end
                  S_PAR: begin
                     txd_q  <= ^tsh_q ^ m1_q[i].par_odd;
                     tcnt_q <= tdiv - 20'h1;
                     tst_q  <= S_STOP;
                  end
                  S_STOP: begin // Idle waits out the stop time
                     txd_q  <= 1'b1;
                     tcnt_q <= m1_q[i].two_stop ?
                               20'({tdiv, 1'b0} - 21'h1) : tdiv - 20'h1;
                     tst_q  <= S_IDLE;
                  end
                  default: tst_q <= S_IDLE;
               endcase
            end
         end
      end

      // Modem change detection
      always_ff @(posedge clk or posedge reset) begin : p_modem
         if (reset) begin
            mprev_q  <= 2'h0;
            dsc_q[i] <= 1'b0;
         end else begin
            mprev_q  <= {f_q.dsr[i], f_q.dcd[i]};
            dsc_q[i] <= chg_w[i] || (dsc_q[i] && !(wr_go &&
                        sel_kind == REG_DSC && f_q.din[i]));
         end
      end

      assign chg_w[i] = mprev_q != {f_q.dsr[i], f_q.dcd[i]};
      assign st = '{dcd: f_q.dcd[i], dsr: f_q.dsr[i], txe: !hfull_q,
                    ferr: ferr_q, perr: perr_q, ovr: ovr_q,
                    full: fcnt_q == 2'h2, rdy: fcnt_q != 2'h0};
      assign rdat_w[i] = sel_kind == REG_DATA   ? f0_q :
                         sel_kind == REG_STATUS ? st :
                         sel_kind == REG_MODE1  ? m1_q[i] :
                         sel_kind == REG_MODE2  ? m2_q[i] :
                         sel_kind == REG_CMD    ? cmd_q[i] : 8'h00;
      // Per-line enables gate each source
      assign rx_pend[i] = cmd_q[i].rxie && (fcnt_q != 2'h0 ||
                          (dsc_q[i] && m1_q[i].modem_change_irq_enable && cmd_q[i].mcie2));
      assign tx_pend[i] = cmd_q[i].txie && cmd_q[i].tx_en && !hfull_q;
      assign serial_output_lines[i] = txd_q;
   end

   // Scanner; lowest line wins, any receiver beats any transmitter
   always_comb begin : p_scan
      sc_hit  = 1'b0;
      sc_dir  = 1'b0;
      sc_line = 3'h0;
      for (int k = LINES - 1; k >= 0; k--) begin
         if (tx_pend[k]) begin
            sc_hit  = 1'b1;
            sc_dir  = 1'b1;
            sc_line = 3'(k);
         end
      end
      for (int k = LINES - 1; k >= 0; k--) begin
         if (rx_pend[k]) begin
            sc_hit  = 1'b1;
            sc_dir  = 1'b0;
            sc_line = 3'(k);
         end
      end
   end

   // Registered so the summary and pins never glitch mid-read
   always_ff @(posedge clk or posedge reset) begin : p_isum
      if (reset) isum_q <= '0;
      else isum_q <= '{valid: sc_hit, dir: sc_dir, spare: 3'h0,
                        line: sc_line};
   end

   // Read multiplexer
   always_comb begin : p_rdmux
      case (sel_kind)
         REG_ISUM: rd_val = isum_q;
         REG_DSC:  rd_val = dsc_q;
         default:  rd_val = rdat_w[sel_line];
      endcase
   end

   // Host bus: data latched at strobe start and held to its end
   always_ff @(posedge clk or posedge reset) begin : p_host
      if (reset) begin
         acc_q  <= 1'b0;
         dout_q <= 8'h00;
         oe_q   <= 1'b0;
         rdy_q  <= 1'b0;
      end else begin
         acc_q <= acc;
         if (rd_go) dout_q <= rd_val;
         oe_q  <= acc && f_q.wr_n;
         rdy_q <= acc && acc_q;
      end
   end

   assign parallel_data_lines_out      = dout_q;
   assign parallel_data_lines_oe       = oe_q;
   assign ready                        = rdy_q;
   assign irq                          = isum_q.valid;
   assign interrupt_source_line_number = isum_q.line;
   assign interrupt_direction_flag     = isum_q.dir;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   ready_rises_a: assert property (start ##1 acc [*2] |-> rdy_q)
      else $error("ready not raised during access");
   oe_in_read_a: assert property (oe_q |-> $past(acc && f_q.wr_n))
      else $error("data driven outside a read");
   read_stable_a: assert property (oe_q && $past(oe_q) |-> $stable(dout_q))
      else $error("read data changed during strobe");
   rx_first_a: assert property (isum_q.valid && isum_q.dir |-> $past(rx_pend) == 8'h00)
      else $error("transmitter reported over receiver");
   line_match_a: assert property (irq && !isum_q.dir |-> |($past(rx_pend) & (8'h01 << isum_q.line)))
      else $error("reported line has no receiver request");
   irq_follow_a: assert property ((rx_pend | tx_pend) != 8'h00 |=> irq)
      else $error("pending request not reported");
   dsc_sets_a: assert property (chg_w != 8'h00 |=> (dsc_q & $past(chg_w)) == $past(chg_w))
      else $error("modem change flag missed");
   modem_change_irq_enable_gate_a: assert property (g_line[1].fcnt_q == 2'h0 &&
      !(m1_q[1].modem_change_irq_enable && cmd_q[1].mcie2) |-> !rx_pend[1])
      else $error("modem interrupt without enable");
   start_bit_a: assert property ($fell(serial_output_lines[3]) |-> (!serial_output_lines[3]) [*4])
      else $error("short low bit on line three");
   fifo_bound_a: assert property (g_line[5].fcnt_q != 2'h3)
      else $error("receive queue overfilled");

   host_write_c: cover property (wr_go ##[1:40] rd_go);
   rx_irq_c: cover property (irq && !isum_q.dir);
   tx_irq_c: cover property (irq && isum_q.dir);
   overrun_c: cover property (g_line[5].ovr_q);
endmodule : osc_octal_uart

// >>> core/osc_pkg.sv
package osc_pkg;
   localparam int LINES  = 8;          // Serial lines in the block
   localparam int CLK_HZ = 25_000_000; // Core clock rate

   // Register kind in select bits [2:0]; line number in bits [5:3]
   localparam logic [2:0] REG_DATA   = 3'h0; // Rx queue read, tx hold write
   localparam logic [2:0] REG_STATUS = 3'h1; // Line status, read only
   localparam logic [2:0] REG_MODE1  = 3'h2; // Framing and modem enable
   localparam logic [2:0] REG_MODE2  = 3'h3; // Rx and tx rate select
   localparam logic [2:0] REG_CMD    = 3'h4; // Line command
   localparam logic [2:0] REG_ISUM   = 3'h5; // Interrupt summary, any line
   localparam logic [2:0] REG_DSC    = 3'h6; // Data-set-change summary

   // Reset values
   localparam logic [7:0] MODE1_RST = 8'h03; // 8 data, no parity, 1 stop
   localparam logic [7:0] MODE2_RST = 8'hee; // 9600 both ways
   localparam logic [7:0] CMD_RST   = 8'h00; // Everything off

   typedef struct packed {
      logic [1:0] spare;
      logic       modem_change_irq_enable;     // modem_change_irq_enable, first of two
      logic       two_stop; // Two stop bits when set
      logic       par_odd;  // Odd parity when set
      logic       par_en;   // Parity bit present
      logic [1:0] len;      // Data bits minus five
   } osc_mode1_s;

   typedef struct packed {
      logic [3:0] tx_rate;
      logic [3:0] rx_rate;
   } osc_mode2_s;

   typedef struct packed {
      logic       clr_err;  // Write-only strobe, clears sticky errors
      logic [1:0] spare;
      logic       mcie2;    // Second modem change enable
      logic       txie;     // Transmit interrupt enable
      logic       rxie;     // Receive interrupt enable
      logic       rx_en;
      logic       tx_en;
   } osc_cmd_s;

   typedef struct packed {
      logic dcd, dsr, txe, ferr, perr, ovr, full, rdy;
   } osc_status_s;

   typedef struct packed {
      logic       valid;
      logic       dir;      // 1 transmitter, 0 receiver
      logic [2:0] spare;
      logic [2:0] line;
   } osc_isum_s;

   // Raw pins as sampled through the input synchroniser
   typedef struct packed {
      logic [7:0] rxd, dsr, dcd;
      logic       cs_n, wr_n;
      logic [1:0] ds_n;
      logic [5:0] sel;
      logic [7:0] din;
   } osc_pins_s;
   localparam int SYNC_W = $bits(osc_pins_s);
   localparam logic [SYNC_W-1:0] SYNC_RST = {8'hff, 16'h0000, 4'hf, 14'h0000};

   typedef enum {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} osc_ser_e;

   // Rate table in tenths of a baud
   function automatic logic [31:0] osc_rate_x10(input logic [3:0] sel);
      case (sel)
         4'h0: osc_rate_x10 = 32'd500;
         4'h1: osc_rate_x10 = 32'd750;
         4'h2: osc_rate_x10 = 32'd1100;
         4'h3: osc_rate_x10 = 32'd1345;
         4'h4: osc_rate_x10 = 32'd1500;
         4'h5: osc_rate_x10 = 32'd3000;
         4'h6: osc_rate_x10 = 32'd6000;
         4'h7: osc_rate_x10 = 32'd12000;
         4'h8: osc_rate_x10 = 32'd18000;
         4'h9: osc_rate_x10 = 32'd20000;
         4'ha: osc_rate_x10 = 32'd24000;
         4'hb: osc_rate_x10 = 32'd36000;
         4'hc: osc_rate_x10 = 32'd48000;
         4'hd: osc_rate_x10 = 32'd72000;
         4'he: osc_rate_x10 = 32'd96000;
         default: osc_rate_x10 = 32'd192000;
      endcase
   endfunction : osc_rate_x10
endpackage : osc_pkg

// >>> tb/osc_modem_model.sv
`timescale 1ns/1ns
module osc_modem_model #(
   parameter int DIV = 13 // Clocks per bit
) (
   // Clock
   input  wire logic       clk,
   // Serial lines, modem side
   input  wire logic [7:0] txd,
   output logic      [7:0] rxd,
   // Modem status levels
   output logic      [7:0] dsr,
   output logic      [7:0] dcd
);
   // Lines idle high and modems start not ready
   initial begin
      rxd = 8'hff;
      dsr = 8'h00;
      dcd = 8'h00;
   end

   // Frame one 8N1 character onto a receive line
   task automatic send(input int ln, input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         rxd[ln] <= f[i];
         repeat (DIV - 1) @(posedge clk);
      end
   endtask : send

   // Capture one 8N1 character; ok low on timeout or bad framing
   task automatic recv(input int ln, output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      b = 8'h00;
      // Bounded wait so a silent line cannot hang the run
      while (txd[ln] !== 1'b0 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      repeat (DIV / 2) @(posedge clk);
      ok = (txd[ln] === 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (DIV) @(posedge clk);
         b[i] = txd[ln];
      end
      repeat (DIV) @(posedge clk);
      ok = ok && (txd[ln] === 1'b1);
   endtask : recv
endmodule : osc_modem_model

// >>> tb/osc_octal_uart_tb_top.sv
`timescale 1ns/1ns
module osc_octal_uart_tb_top
   import osc_pkg::*;
;
   localparam int CLKP = 250000;         // Shortened core rate
   localparam int DIV  = CLKP*10/192000; // Clocks per bit at code f
   logic       clk, reset, cs_n, wr_n, oe, ready, irq, idir;
   logic [1:0] ds_n;
   logic [2:0] iln;
   logic [5:0] sel;
   logic [7:0] din, dout, rxd, txd, dsr, dcd;
   int         error_cnt, compares;

   osc_octal_uart #(.CLK_HZ_P(CLKP)) u_osc_octal_uart (
      .clk(clk), .reset(reset), .register_select_bits(sel),
      .chip_select_n(cs_n), .data_strobe_pair_n(ds_n), .write_n(wr_n),
      .parallel_data_lines_in(din), .parallel_data_lines_out(dout),
      .parallel_data_lines_oe(oe), .ready(ready), .irq(irq),
      .interrupt_source_line_number(iln),
      .interrupt_direction_flag(idir), .serial_input_lines(rxd),
      .serial_output_lines(txd), .dsr_in(dsr), .dcd_in(dcd));
   osc_modem_model #(.DIV(DIV)) u_osc_modem_model (
      .clk(clk), .txd(txd), .rxd(rxd), .dsr(dsr), .dcd(dcd));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Single exit point for both normal end and watchdog
   task automatic finish_test;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One strobed access; inputs held long past the synchroniser delay
   task automatic bus(input logic [5:0] a, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk);
      sel  <= a;
      din  <= d;
      wr_n <= ~w;
      cs_n <= 1'b0;
      @(posedge clk);
      ds_n <= 2'b00;
      do begin
         @(negedge clk);
         n++;
      end while (ready !== 1'b1 && n < 40);
      q = dout;
      chk({7'h00, oe}, {7'h00, ~w});
      chk({7'h00, ready}, 8'h01);
      @(posedge clk);
      ds_n <= 2'b11;
      cs_n <= 1'b1;
      repeat (8) @(negedge clk);
      chk({6'h00, oe, ready}, 8'h00);
   endtask : bus

   task automatic wrc(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask : wrc

   task automatic rdc(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk(q, e);
   endtask : rdc

   task automatic t_reset;
      chk({5'h00, irq, ready, oe}, 8'h00);
      chk(txd, 8'hff);
      rdc({3'd0, REG_MODE1}, MODE1_RST);
      rdc({3'd7, REG_MODE2}, MODE2_RST);
      rdc({3'd4, REG_CMD}, CMD_RST);
      wrc({3'd0, REG_STATUS}, 8'hff);
      rdc({3'd0, REG_STATUS}, 8'h20);
      $display("test reset done");
   endtask : t_reset

   task automatic t_tx;
      logic [7:0] b;
      logic       ok;
      wrc({3'd3, REG_MODE2}, 8'hff);
      wrc({3'd3, REG_CMD}, 8'h01);
      fork
         wrc({3'd3, REG_DATA}, 8'ha5);
         u_osc_modem_model.recv(3, b, ok);
      join
      chk({7'h00, ok}, 8'h01);
      chk(b, 8'ha5);
      chk(txd, 8'hff);
      $display("test tx done");
   endtask : t_tx

   // Three characters into a two-entry queue: third is lost
   task automatic t_rx;
      wrc({3'd5, REG_MODE2}, 8'hff);
      wrc({3'd5, REG_CMD}, 8'h02);
      u_osc_modem_model.send(5, 8'h11);
      u_osc_modem_model.send(5, 8'h22);
      u_osc_modem_model.send(5, 8'h33);
      repeat (DIV) @(negedge clk);
      rdc({3'd5, REG_STATUS}, 8'h27);
      rdc({3'd5, REG_DATA}, 8'h11);
      rdc({3'd5, REG_DATA}, 8'h22);
      rdc({3'd5, REG_STATUS}, 8'h24);
      // Parity on: the model's stop bit fills the parity slot
      wrc({3'd5, REG_MODE1}, 8'h07);
      u_osc_modem_model.send(5, 8'h11);
      repeat (2 * DIV) @(negedge clk);
      rdc({3'd5, REG_STATUS}, 8'h2d);
      rdc({3'd5, REG_DATA}, 8'h11);
      wrc({3'd5, REG_CMD}, 8'h82);
      rdc({3'd5, REG_STATUS}, 8'h20);
      rdc({3'd5, REG_CMD}, 8'h02);
      wrc({3'd5, REG_MODE1}, MODE1_RST);
      $display("test rx done");
   endtask : t_rx

   task automatic t_irq;
      wrc({3'd2, REG_CMD}, 8'h09);
      chk({3'h0, irq, idir, iln}, 8'h1a);
      rdc({3'd0, REG_ISUM}, 8'hc2);
      wrc({3'd5, REG_CMD}, 8'h06);
      u_osc_modem_model.send(5, 8'h44);
      repeat (DIV) @(negedge clk);
      chk({3'h0, irq, idir, iln}, 8'h15);
      rdc({3'd6, REG_ISUM}, 8'h85);
      rdc({3'd5, REG_DATA}, 8'h44);
      chk({3'h0, irq, idir, iln}, 8'h1a);
      wrc({3'd2, REG_CMD}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      $display("test irq done");
   endtask : t_irq

   // Modem change needs both enables plus receive interrupt enable
   task automatic t_modem;
      wrc({3'd1, REG_MODE1}, 8'h23);
      wrc({3'd1, REG_CMD}, 8'h04);
      @(posedge clk);
      u_osc_modem_model.dsr[1] <= 1'b1;
      repeat (8) @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      rdc({3'd0, REG_DSC}, 8'h02);
      rdc({3'd1, REG_STATUS}, 8'h60);
      wrc({3'd1, REG_CMD}, 8'h14);
      chk({3'h0, irq, idir, iln}, 8'h11);
      wrc({3'd0, REG_DSC}, 8'h02);
      rdc({3'd0, REG_DSC}, 8'h00);
      chk({7'h00, irq}, 8'h00);
      $display("test modem done");
   endtask : t_modem

   initial begin
      reset     = 1'b1;
      cs_n      = 1'b1;
      ds_n      = 2'b11;
      wr_n      = 1'b1;
      sel       = 6'h00;
      din       = 8'h00;
      error_cnt = 0;
      compares  = 0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (8) @(negedge clk);
      t_reset();
      t_tx();
      t_rx();
      t_irq();
      t_modem();
      finish_test();
   end

   // Tests need about 1500 clocks; twenty times that means a hang
   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      finish_test();
   end
endmodule : osc_octal_uart_tb_top
